// File: rtl/drvctl_pkg.sv
// Package for the driver mode and protection supervisor.
// Assumes a 40 MHz logic clock and a frame decoder that delivers complete 24-bit command words.
package drvctl_pkg;

    // ------------------------------------------------------------
    // Sizes and field positions
    // ------------------------------------------------------------
    localparam int unsigned NUM_OUT        = 11;
    localparam int unsigned WORD_W         = 24;
    localparam int unsigned MODE_BIT       = 23;
    localparam int unsigned SUPPLY_REC_BIT = 20;
    localparam logic [4:0]  FRAME_BITS     = 5'h18;

    // ------------------------------------------------------------
    // Timing: figures in ns, then cycles at 25 ns
    // ------------------------------------------------------------
    localparam int unsigned CLK_NS          = 25;
    localparam int unsigned WAKE_MAX_NS     = 300000;
    localparam int unsigned XFER_MAX_NS     = 4000;
    localparam int unsigned DIAG_MIN_NS     = 32000;
    localparam int unsigned OPEN_MIN_NS     = 1000000;
    localparam int unsigned WAKE_CYC        = WAKE_MAX_NS / CLK_NS;
    localparam int unsigned XFER_CYC        = XFER_MAX_NS / CLK_NS;
    localparam int unsigned DIAG_CYC        = (DIAG_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned OPEN_CYC        = (OPEN_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W           = 16;

    // ------------------------------------------------------------
    // Reset values and types
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] CMD_RESET  = 24'h00_0000;
    localparam logic [NUM_OUT-1:0] OUT_RESET = 11'h000;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_WAKE    = 3'b010,
        ST_ACTIVE  = 3'b100
    } mode_state_t;

    // Raw analog comparator results
    typedef struct packed {
        logic [NUM_OUT-1:0] over_current;
        logic [NUM_OUT-1:0] open_load;
        logic               over_volt;
        logic               under_volt;
        logic               temp_warn;
        logic               therm_shut;
    } diag_raw_t;

    // Latched status
    typedef struct packed {
        logic [NUM_OUT-1:0] over_current;
        logic [NUM_OUT-1:0] open_load;
        logic               over_volt;
        logic               under_volt;
        logic               temp_warn;
        logic               therm_shut;
    } diag_stat_t;

endpackage : drvctl_pkg

// File: rtl/persist_filter.sv
// Persistence filter: output rises once the input has stood high for LIMIT cycles in a row.
// Assumes the input is already synchronous to core_clk.
module persist_filter
    import drvctl_pkg::*;
#(
    parameter int unsigned LIMIT = 4
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Condition
    input  wire logic cond_in,
    output logic      cond_ok
);
    localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT - 1);
    logic [CNT_W-1:0] count_reg;

    // A gap restarts the count, so only a continuous condition passes
    always_ff @(posedge core_clk) begin
        if (rst || !cond_in) begin
            count_reg <= '0;
            cond_ok   <= 1'b0;
        end else if (count_reg == LIM) begin
            cond_ok   <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !cond_in |=> !cond_ok) else $error("filter output without condition");
endmodule : persist_filter

// File: rtl/drvctl_top.sv
// Mode control, wake timing, diagnostic latching and output protection for an 11-output driver.
// Assumes: frame decoder gives word, bit count and select_low_pin-rise pulse on core_clk;
// rst is the internal power-on reset; raw diagnostics come from asynchronous comparators.
// Functional notes
// - Clearing command bit 23 puts the device into standby.
// - Standby clears latched data and floats inputs and outputs.
// - Setting command bit 23 switches the device to active mode.
// - Leaving standby, drivers enable within 300 us after select rises.
// - Active-mode command is transferred within 4 us of select rising.
// - Logic supply rising from undervoltage initialises all logic by reset; the synchronisers and diagnostic filters are reset by rst only.
// - Logic supply below threshold floats outputs and clears status.
// - Diagnostics must persist 32 us, open load 1 ms, before flagging.
// - Open load and temperature warning never change driver state.
// - Overload disables its driver; thermal shutdown disables all drivers.
// - Without recovery bit, overloaded driver stays off until status cleared.
// - Supply over or undervoltage floats all eleven power outputs.
// - With bit 20 clear, outputs return automatically after supply fault.
// - With bit 20 set, no automatic return after supply fault.
// - Only frames of exactly 24 clocks are written; others discarded.
// - After thermal shutdown, restart needs cool-down and cleared status.
module drvctl_top
    import drvctl_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst,
    // Frame decoder
    input  wire logic               frame_end,
    input  wire logic [4:0]         frame_bits,
    input  wire logic [WORD_W-1:0]  frame_word,
    // Controller status clears and recovery enables
    input  wire logic [NUM_OUT-1:0] clr_over_current,
    input  wire logic               clr_supply,
    input  wire logic               clr_therm,
    input  wire logic [NUM_OUT-1:0] oc_recovery,
    // Raw conditions from asynchronous comparators
    input  wire diag_raw_t          diag_raw,
    input  wire logic               logic_uv,
    // Outputs
    output logic [NUM_OUT-1:0]      drive_on,
    output logic [NUM_OUT-1:0]      drive_oe,
    output logic                    inputs_en,
    output logic                    active_mode,
    output logic [WORD_W-1:0]       cmd_reg,
    output diag_stat_t              status_reg
);
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    localparam int unsigned RAW_W = $bits(diag_raw_t);
    logic [RAW_W:0] sync1_reg;
    logic [RAW_W:0] sync2_reg;
    diag_raw_t      raw_s;
    logic           logic_uv_s;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {logic_uv, diag_raw};
            sync2_reg <= sync1_reg;
        end
    end
    assign raw_s      = diag_raw_t'(sync2_reg[RAW_W-1:0]);
    assign logic_uv_s = sync2_reg[RAW_W];

    // ------------------------------------------------------------
    // Diagnostic filters
    // ------------------------------------------------------------
    diag_raw_t filt;
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            persist_filter #(.LIMIT(DIAG_CYC)) u_oc (
                .core_clk(core_clk), .rst(rst), .cond_in(raw_s.over_current[g]),
                .cond_ok(filt.over_current[g]));
            persist_filter #(.LIMIT(OPEN_CYC)) u_ol (
                .core_clk(core_clk), .rst(rst), .cond_in(raw_s.open_load[g]),
                .cond_ok(filt.open_load[g]));
        end
        for (g = 0; g < 4; g++) begin : g_glb
            persist_filter #(.LIMIT(DIAG_CYC)) u_f (
                .core_clk(core_clk), .rst(rst), .cond_in(raw_s[g]), .cond_ok(filt[g]));
        end
    endgenerate

    // ------------------------------------------------------------
    // Command acceptance and mode machine
    // ------------------------------------------------------------
    mode_state_t       state_reg;
    logic [CNT_W-1:0]  wake_reg;
    logic              good_frame;
    // Ends two cycles early: the state register and the output register follow it,
    // so the drivers come on one cycle inside the wake limit after the frame ends
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 3);

    assign good_frame = frame_end && (frame_bits == FRAME_BITS);

    // Word is taken the cycle after select rises, well inside the transfer window
    always_ff @(posedge core_clk) begin
        if (rst || logic_uv_s) begin
            cmd_reg <= CMD_RESET;
        end else if (good_frame) begin
            cmd_reg <= frame_word;
        end else if (state_reg == ST_STANDBY) begin
            cmd_reg <= CMD_RESET;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || logic_uv_s) begin
            state_reg <= ST_STANDBY;
            wake_reg  <= '0;
        end else begin
            case (state_reg)
                ST_STANDBY: begin
                    wake_reg <= '0;
                    if (good_frame && frame_word[MODE_BIT]) state_reg <= ST_WAKE;
                end
                ST_WAKE: begin
                    wake_reg <= wake_reg + 1'b1;
                    if (good_frame && !frame_word[MODE_BIT]) state_reg <= ST_STANDBY;
                    else if (wake_reg == WAKE_LAST) state_reg <= ST_ACTIVE;
                end
                ST_ACTIVE: begin
                    if (good_frame && !frame_word[MODE_BIT]) state_reg <= ST_STANDBY;
                end
                default: state_reg <= ST_STANDBY;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status latches: a new event beats a clear in the same cycle
    // ------------------------------------------------------------
    logic stb;
    assign stb = (state_reg == ST_STANDBY);

    always_ff @(posedge core_clk) begin
        if (rst || logic_uv_s || stb) begin
            status_reg <= '0;
        end else begin
            status_reg.over_current <= filt.over_current | (status_reg.over_current & ~clr_over_current);
            status_reg.open_load    <= filt.open_load | status_reg.open_load;
            status_reg.over_volt    <= filt.over_volt | (status_reg.over_volt & ~clr_supply);
            status_reg.under_volt   <= filt.under_volt | (status_reg.under_volt & ~clr_supply);
            status_reg.temp_warn    <= filt.temp_warn | status_reg.temp_warn;
            status_reg.therm_shut   <= filt.therm_shut | (status_reg.therm_shut & ~clr_therm);
        end
    end

    // ------------------------------------------------------------
    // Output gating
    // ------------------------------------------------------------
    // Open load and warning are left out of this mask on purpose
    logic [NUM_OUT-1:0] oc_block;
    logic               supply_now;
    logic               supply_block;
    logic               all_block;
    assign supply_now   = filt.over_volt | filt.under_volt;
    assign supply_block = supply_now | (cmd_reg[SUPPLY_REC_BIT] &
                          (status_reg.over_volt | status_reg.under_volt));
    assign oc_block     = filt.over_current | (status_reg.over_current & ~oc_recovery);
    assign all_block    = filt.therm_shut | status_reg.therm_shut;

    always_ff @(posedge core_clk) begin
        if (rst || logic_uv_s) begin
            drive_on    <= OUT_RESET;
            drive_oe    <= OUT_RESET;
            inputs_en   <= 1'b0;
            active_mode <= 1'b0;
        end else begin
            active_mode <= (state_reg == ST_ACTIVE);
            inputs_en   <= !stb;
            if (state_reg != ST_ACTIVE || supply_block || all_block) begin
                drive_on <= OUT_RESET;
                drive_oe <= OUT_RESET;
            end else begin
                drive_oe <= ~oc_block;
                drive_on <= cmd_reg[NUM_OUT-1:0] & ~oc_block;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Cycles spent waking; a counter because the window is far too long for a delay range
    logic [CNT_W-1:0]   wake_wait_reg;
    logic [NUM_OUT-1:0] oc_latched_off;
    logic [NUM_OUT-1:0] cmd_drive_bits;
    assign oc_latched_off = status_reg.over_current & ~oc_recovery;
    assign cmd_drive_bits = cmd_reg[NUM_OUT-1:0];

    always_ff @(posedge core_clk) begin
        if (rst || logic_uv_s || stb || active_mode) begin
            wake_wait_reg <= '0;
        end else if (wake_wait_reg != '1) begin
            wake_wait_reg <= wake_wait_reg + 1'b1;
        end
    end

    bad_frame_a: assert property (@(posedge core_clk) disable iff (rst || logic_uv_s)
        (frame_end && frame_bits != FRAME_BITS) |=> $stable(cmd_reg) || $past(stb))
        else $error("short or long frame changed command");
    wake_time_a: assert property (@(posedge core_clk) disable iff (rst || logic_uv_s)
        wake_wait_reg < CNT_W'(WAKE_CYC))
        else $error("wake delay exceeded");
    standby_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == ST_ACTIVE && good_frame && !frame_word[MODE_BIT]) |=> ##1 drive_oe == '0)
        else $error("outputs not floated in standby");
    cmd_load_a: assert property (@(posedge core_clk) disable iff (rst || logic_uv_s)
        good_frame |=> cmd_reg == $past(frame_word))
        else $error("command not transferred");
    supply_off_a: assert property (@(posedge core_clk) disable iff (rst)
        supply_now |=> drive_oe == '0) else $error("outputs live in supply fault");
    therm_off_a: assert property (@(posedge core_clk) disable iff (rst)
        status_reg.therm_shut |=> drive_on == '0) else $error("driver on after shutdown");
    uv_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        logic_uv_s |=> status_reg == '0 && drive_oe == '0) else $error("logic uv not cleared");
    oc_stay_a: assert property (@(posedge core_clk) disable iff (rst)
        oc_latched_off != '0 |=> (drive_on & $past(oc_latched_off)) == '0)
        else $error("overloaded driver restarted");
    warn_free_a: assert property (@(posedge core_clk) disable iff (rst || logic_uv_s)
        (state_reg == ST_ACTIVE && !supply_block && !all_block && oc_block == '0 && $stable(cmd_reg))
        |=> drive_on == $past(cmd_drive_bits)) else $error("warning changed outputs");

    wake_c:   cover property (@(posedge core_clk) $rose(active_mode));
    oc_c:     cover property (@(posedge core_clk) $rose(|status_reg.over_current));
    supply_c: cover property (@(posedge core_clk) $rose(status_reg.under_volt));
    therm_c:  cover property (@(posedge core_clk) $fell(status_reg.therm_shut));
endmodule : drvctl_top

// File: tb/uc_model.sv
// Controller model: sends command frames to the frame decoder ports and clears status bits.
// Assumes one calling process; every line it owns changes on the falling clock edge.
module uc_model
    import drvctl_pkg::*;
(
    // Clock
    input  wire logic          core_clk,
    // Frame and clears
    output logic               frame_end,
    output logic [4:0]         frame_bits,
    output logic [WORD_W-1:0]  frame_word,
    output logic [NUM_OUT-1:0] clr_over_current,
    output logic               clr_supply,
    output logic               clr_therm
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {frame_end, clr_supply, clr_therm} = 3'h0;
        frame_bits = 5'h00;
        frame_word = 24'h00_0000;
        clr_over_current = 11'h000;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic send(input logic [WORD_W-1:0] w, input logic [4:0] n, input bit slow);
        @(negedge core_clk);
        {frame_end, frame_bits, frame_word} = {1'b1, n, w};
        @(negedge core_clk);
        // Released lines show the inverse so a stale word never looks valid
        {frame_end, frame_bits, frame_word} = {1'b0, ~n, ~w};
        repeat (slow ? 50000 / CLK_NS : XFER_CYC) @(negedge core_clk);
    endtask : send

    task automatic clear(input logic [NUM_OUT-1:0] oc, input logic sup, input logic th);
        @(negedge core_clk);
        {clr_over_current, clr_supply, clr_therm} = {oc, sup, th};
        @(negedge core_clk);
        {clr_over_current, clr_supply, clr_therm} = 13'h0000;
    endtask : clear
endmodule : uc_model

// File: tb/tb_drvctl_top.sv
// Bench for drvctl_top: the controller model sends frames, the bench drives raw conditions.
// Assumes the package timing constants; expectations are queued and a watcher compares them.
`define CHECK(nm, e, g) \
    begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_drvctl_top
    import drvctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; int sel; logic [31:0] e;} note_t;
    logic               core_clk, rst, frame_end, clr_supply, clr_therm, logic_uv;
    logic               inputs_en, active_mode;
    logic [4:0]         frame_bits;
    logic [WORD_W-1:0]  frame_word, cmd_reg, w, v;
    logic [NUM_OUT-1:0] clr_over_current, oc_recovery, drive_on, drive_oe, all_on;
    diag_raw_t          diag_raw, dr;
    diag_stat_t         status_reg, es;
    note_t              notes[$];
    event               note_ev;
    int                 err_count, tests_run, cycles, idx;

    drvctl_top u_drvctl_top (.core_clk, .rst, .frame_end, .frame_bits, .frame_word, .clr_over_current,
        .clr_supply, .clr_therm, .oc_recovery, .diag_raw, .logic_uv, .drive_on, .drive_oe, .inputs_en,
        .active_mode, .cmd_reg, .status_reg);
    uc_model u_uc_model (.core_clk, .frame_end, .frame_bits, .frame_word, .clr_over_current,
        .clr_supply, .clr_therm);

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // The whole run needs about 80000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            test_done();
        end
    end

    function automatic logic [31:0] seen(input int sel);
        case (sel)
            0: seen = 32'(drive_on & drive_oe);
            1: seen = 32'(drive_oe);
            2: seen = {30'h0, inputs_en, active_mode};
            3: seen = 32'(cmd_reg);
            default: seen = 32'(status_reg);
        endcase
    endfunction : seen

    task automatic note(input string nm, input int sel, input logic [31:0] e);
        notes.push_back('{nm, sel, e});
        -> note_ev;
    endtask : note

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic hold(input diag_raw_t r, input int n);
        @(negedge core_clk);
        diag_raw = r;
        repeat (n) @(negedge core_clk);
    endtask : hold

    task automatic wake(input logic [WORD_W-1:0] x);
        u_uc_model.send(x, FRAME_BITS, 1'b1);
        repeat (WAKE_CYC + 3 - 50000 / CLK_NS) @(negedge core_clk);
    endtask : wake

    initial begin : watch
        note_t c;
        forever begin
            @(note_ev);
            while (notes.size() > 0) begin
                c = notes.pop_front();
                `CHECK(c.nm, c.e, seen(c.sel))
            end
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin : main
        rst = 1'b1;
        logic_uv = 1'b0;
        diag_raw = '0;
        oc_recovery = 11'h000;
        all_on = 11'h7FF;
        void'($urandom(68987));
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        note("mode", 2, 32'h0000_0000);
        note("oe", 1, 32'h0000_0000);
        idx = $urandom_range(NUM_OUT - 1, 0);
        w = {1'b1, 12'($urandom), all_on};
        w[SUPPLY_REC_BIT] = 1'b0;
        wake(w);
        note("cmd", 3, 32'(w));
        note("mode", 2, 32'h0000_0003);
        note("drive", 0, 32'(all_on));
        for (int n = 23; n <= 25; n += 2) begin
            u_uc_model.send(24'($urandom) & 24'h7F_FFFF, 5'(n), 1'b0);
            note("cmd", 3, 32'(w));
            note("mode", 2, 32'h0000_0003);
        end
        v = {1'b1, 23'($urandom)};
        v[SUPPLY_REC_BIT] = 1'b0;
        u_uc_model.send(v, FRAME_BITS, 1'b0);
        note("cmd", 3, 32'(v));
        note("drive", 0, 32'(v[NUM_OUT-1:0]));
        u_uc_model.send(w, FRAME_BITS, 1'b0);
        $display("frames done");
        dr = '0;
        dr.over_current[idx] = 1'b1;
        repeat (2) begin
            hold(dr, DIAG_CYC - 6);
            hold('0, 3);
        end
        note("status", 4, 32'h0000_0000);
        for (int r = 0; r < 2; r++) begin
            oc_recovery[idx] = r[0];
            hold(dr, DIAG_CYC + 8);
            es = '0;
            es.over_current[idx] = 1'b1;
            note("status", 4, 32'(es));
            note("drive", 0, 32'(all_on & ~(11'h001 << idx)));
            hold('0, 8);
            note("drive", 0, 32'(r ? all_on : all_on & ~(11'h001 << idx)));
            u_uc_model.clear(11'h001 << idx, 1'b0, 1'b0);
            repeat (4) @(negedge core_clk);
            note("drive", 0, 32'(all_on));
        end
        oc_recovery = 11'h000;
        dr = '0;
        dr.therm_shut = 1'b1;
        hold(dr, DIAG_CYC + 8);
        note("drive", 0, 32'h0000_0000);
        u_uc_model.clear(11'h000, 1'b0, 1'b1);
        hold('0, 8);
        note("drive", 0, 32'h0000_0000);
        u_uc_model.clear(11'h000, 1'b0, 1'b1);
        repeat (4) @(negedge core_clk);
        note("drive", 0, 32'(all_on));
        $display("overload and thermal done");
        for (int k = 0; k < 4; k++) begin
            dr = '0;
            dr.over_volt = k[0];
            dr.under_volt = !k[0];
            if (k == 2) begin
                w[SUPPLY_REC_BIT] = 1'b1;
                u_uc_model.send(w, FRAME_BITS, 1'b0);
            end
            hold(dr, DIAG_CYC + 8);
            note("oe", 1, 32'h0000_0000);
            hold('0, 8);
            note("oe", 1, 32'(k < 2 ? all_on : 11'h000));
            u_uc_model.clear(11'h000, 1'b1, 1'b0);
            repeat (4) @(negedge core_clk);
            note("drive", 0, 32'(all_on));
        end
        $display("supply done");
        dr = '0;
        dr.open_load[idx] = 1'b1;
        dr.temp_warn = 1'b1;
        hold(dr, DIAG_CYC + 8);
        es = '0;
        es.temp_warn = 1'b1;
        note("status", 4, 32'(es));
        repeat (OPEN_CYC) @(negedge core_clk);
        es.open_load[idx] = 1'b1;
        note("status", 4, 32'(es));
        note("drive", 0, 32'(all_on));
        note("oe", 1, 32'(all_on));
        hold('0, 4);
        u_uc_model.send({1'b0, 23'($urandom)}, FRAME_BITS, 1'b0);
        note("mode", 2, 32'h0000_0000);
        note("cmd", 3, 32'h0000_0000);
        note("oe", 1, 32'h0000_0000);
        note("status", 4, 32'h0000_0000);
        $display("info flags and standby done");
        wake(w);
        note("mode", 2, 32'h0000_0003);
        note("drive", 0, 32'(all_on));
        hold(dr, DIAG_CYC + 8);
        logic_uv = 1'b1;
        repeat (4) @(negedge core_clk);
        note("oe", 1, 32'h0000_0000);
        note("status", 4, 32'h0000_0000);
        logic_uv = 1'b0;
        hold('0, 4);
        note("mode", 2, 32'h0000_0000);
        note("cmd", 3, 32'h0000_0000);
        $display("logic supply loss done");
        test_done();
    end
endmodule : tb_drvctl_top
